// File: logic/seq_consts.vh
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
// register word offsets (byte addresses)
`define OFF_CMD 4'h0
`define OFF_ARG 4'h4
`define OFF_REPLY 4'h8
`define OFF_STATUS 4'hc
// command codes written to the command register
`define CMD_FILE 4'h1
`define CMD_STEP 4'h2
`define CMD_TOTAL 4'h3
`define CMD_BANK 4'h4
`define CMD_TIME 4'h5
`define CMD_SAVE 4'h6
`define CMD_REPEAT 4'h7
`define CMD_RUN 4'h8
`define CMD_TESTING 4'h9
`define CMD_STOP 4'ha
// command register fields
`define CMD_QUERY_BIT 4
// status register fields
`define ST_RUNNING 0
`define ST_REJECT 1
`define ST_DONE 2
`define ST_REPLY_VALID 3
// ranges, sized to the 32-bit range check so nothing is padded
`define FILE_MAX 32'h9
`define STEP_MAX 32'h10
`define BANK_MAX 32'h96
`define TIME_MIN 32'h64
`define TIME_MAX 32'h270f
`define REPEAT_MAX 32'h270f
// dwell unit: 1 ms at 40 MHz
`define MS_NS 1000000
`define CLK_NS 25
`endif

// File: logic/seq_mem.v
`timescale 1ns/1ps
`default_nettype none
// single port step store, registered read data
module seq_mem #(
  parameter AW = 8,
  parameter DW = 22
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // write and registered read
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// File: logic/auto_sequence_command_engine.v
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "seq_consts.vh"
module auto_sequence_command_engine #(
  parameter MS_CYCLES = `MS_NS / `CLK_NS
) (
  input wire clk,
  input wire rstn,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  output reg [7:0] bank_apply,
  output reg bank_apply_valid,
  output reg sequence_done
);
  // memory: {bank[7:0], time[13:0]}, address {file 0..9 (0 = edit), step 0..15}
  // file 0 is the working edit buffer; SAVE copies it into the selected file
  localparam S_IDLE = 3'd0;
  localparam S_SAVE = 3'd1;
  localparam S_LOAD = 3'd2;
  localparam S_DWELL = 3'd3;
  localparam S_RD = 3'd4;
  localparam S_RDWAIT = 3'd5;
  localparam S_ACK = 3'd6;

  reg [2:0] state;
  reg [3:0] file_sel;
  reg [4:0] step_sel;
  reg [4:0] total_edit;
  reg [13:0] repeat_edit;
  reg [4:0] total_file [1:9];
  reg [13:0] repeat_file [1:9];
  reg [3:0] run_file;
  reg [4:0] run_step;
  reg [13:0] run_left;
  reg [13:0] ms_left;
  reg [31:0] tick;
  reg running;
  reg reject;
  reg done_flag;
  reg reply_valid;
  reg rd_ready;
  reg [31:0] reply;
  reg [31:0] arg;
  reg [7:0] mem_addr;
  reg mem_we;
  reg [21:0] mem_wdata;
  reg [4:0] copy_idx;
  reg copy_rd;
  reg rd_is_bank;
  wire [21:0] mem_rdata;
  integer i;

  seq_mem #(.AW(8), .DW(22)) u_mem (
    .clk(clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // range check shared by every numeric argument
  function in_range;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  // bus stalls while a memory access or step load is pending; dwell stays open to the host
  wire busy = (state != S_IDLE) && (state != S_DWELL);
  wire cmd_wr = write && !busy && (address == `OFF_CMD);
  wire rd_latch = read && !rd_ready && !busy; // readdata is a flop: latch now, accept next edge
  assign waitrequest = ((read || write) && busy) || (read && !rd_ready);
  wire [3:0] op = writedata[3:0];
  wire query = writedata[`CMD_QUERY_BIT];
  wire [13:0] arg14 = arg[13:0];

  // bus reads
  always @(posedge clk) begin
    if (!rstn) begin
      readdata <= 32'h0;
    end else if (rd_latch) begin
      case (address)
        `OFF_ARG: readdata <= arg;
        `OFF_REPLY: readdata <= reply;
        `OFF_STATUS: readdata <= {28'h0, reply_valid, done_flag, reject, running};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // command interpreter and sequencer
  always @(posedge clk) begin
    if (!rstn) begin
      state <= S_IDLE;
      file_sel <= 4'h1;
      step_sel <= 5'h1;
      total_edit <= 5'h1;
      repeat_edit <= 14'h0;
      for (i = 1; i <= 9; i = i + 1) begin
        total_file[i] <= 5'h1;
        repeat_file[i] <= 14'h0;
      end
      run_file <= 4'h0;
      run_step <= 5'h0;
      run_left <= 14'h0;
      ms_left <= 14'h0;
      tick <= 32'h0;
      running <= 1'b0;
      reject <= 1'b0;
      done_flag <= 1'b0;
      reply_valid <= 1'b0;
      rd_ready <= 1'b0;
      reply <= 32'h0;
      arg <= 32'h0;
      mem_addr <= 8'h0;
      mem_we <= 1'b0;
      mem_wdata <= 22'h0;
      copy_idx <= 5'h0;
      copy_rd <= 1'b0;
      rd_is_bank <= 1'b0;
      bank_apply <= 8'h0;
      bank_apply_valid <= 1'b0;
      sequence_done <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      bank_apply_valid <= 1'b0;
      sequence_done <= 1'b0;
      rd_ready <= rd_latch || (rd_ready && read && busy); // held across a stall, cleared on accept
      if (write && !busy && address == `OFF_ARG) begin
        arg <= writedata;
      end
      // reading status clears done flag, unless completion lands now
      if (rd_latch && address == `OFF_STATUS) begin
        done_flag <= 1'b0;
      end
      if (rd_latch && address == `OFF_REPLY) begin
        reply_valid <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (cmd_wr) begin
            reject <= 1'b0;
            case (op)
              `CMD_FILE: begin
                if (query) begin
                  reply <= {28'h0, file_sel};
                  reply_valid <= 1'b1;
                end else if (in_range(arg, 1, `FILE_MAX)) begin
                  file_sel <= arg[3:0];
                  total_edit <= total_file[arg[3:0]];
                  repeat_edit <= repeat_file[arg[3:0]];
                end else begin
                  reject <= 1'b1;
                end
              end
              `CMD_STEP: begin
                if (query) begin
                  reply <= {27'h0, step_sel};
                  reply_valid <= 1'b1;
                end else if (in_range(arg, 1, `STEP_MAX)) begin
                  step_sel <= arg[4:0];
                end else begin
                  reject <= 1'b1;
                end
              end
              `CMD_TOTAL: begin
                if (query) begin
                  reply <= {27'h0, total_edit};
                  reply_valid <= 1'b1;
                end else if (in_range(arg, 1, `STEP_MAX)) begin
                  total_edit <= arg[4:0];
                end else begin
                  reject <= 1'b1;
                end
              end
              `CMD_BANK, `CMD_TIME: begin
                // both fields share one word, so a set is read-modify-write
                if (!query && !(op == `CMD_BANK ? in_range(arg, 1, `BANK_MAX)
                    : in_range(arg, `TIME_MIN, `TIME_MAX))) begin
                  reject <= 1'b1;
                end else begin
                  mem_addr <= {4'h0, step_sel[3:0] - 4'h1};
                  rd_is_bank <= (op == `CMD_BANK);
                  copy_rd <= query;
                  state <= S_RD;
                end
              end
              `CMD_SAVE: begin
                copy_idx <= 5'h0;
                copy_rd <= 1'b0; // a query leaves it set
                mem_addr <= 8'h0;
                state <= S_SAVE;
              end
              `CMD_REPEAT: begin
                if (query) begin
                  reply <= {18'h0, repeat_edit};
                  reply_valid <= 1'b1;
                end else if (in_range(arg, 0, `REPEAT_MAX)) begin
                  repeat_edit <= arg14;
                end else begin
                  reject <= 1'b1;
                end
              end
              `CMD_RUN: begin
                if (in_range(arg, 1, `FILE_MAX)) begin
                  run_file <= arg[3:0];
                  run_step <= 5'h0;
                  run_left <= repeat_file[arg[3:0]];
                  mem_addr <= {arg[3:0], 4'h0};
                  running <= 1'b1;
                  state <= S_LOAD;
                end else begin
                  reject <= 1'b1;
                end
              end
              `CMD_TESTING: begin
                reply <= {31'h0, running};
                reply_valid <= 1'b1;
              end
              default: reject <= 1'b1;
            endcase
          end
        end
        S_RD: state <= S_RDWAIT; // memory read data land next edge
        S_RDWAIT: begin
          if (copy_rd) begin
            reply <= rd_is_bank ? {24'h0, mem_rdata[21:14]}
                : {18'h0, mem_rdata[13:0]};
            reply_valid <= 1'b1;
          end else begin
            mem_we <= 1'b1;
            mem_wdata <= rd_is_bank ? {arg[7:0], mem_rdata[13:0]}
                : {mem_rdata[21:14], arg14};
          end
          state <= S_ACK;
        end
        S_SAVE: begin
          // copy pass: address an edit word, wait for its registered data, write it to the file
          if (copy_rd) begin
            if (tick == 32'h0) begin
              tick <= 32'h1; // read data register on this edge
            end else begin
              tick <= 32'h0;
              mem_we <= 1'b1;
              mem_wdata <= mem_rdata;
              mem_addr <= {file_sel, copy_idx[3:0]};
              copy_rd <= 1'b0;
              copy_idx <= copy_idx + 5'h1;
            end
          end else if (copy_idx == 5'h10) begin
            total_file[file_sel] <= total_edit;
            repeat_file[file_sel] <= repeat_edit;
            state <= S_ACK;
          end else if (!mem_we) begin
            mem_addr <= {4'h0, copy_idx[3:0]};
            copy_rd <= 1'b1;
          end
        end
        S_LOAD: begin
          // read data register one edge after the address; apply two edges after that
          if (tick != 32'h2) begin
            tick <= tick + 32'h1;
          end else begin
            bank_apply <= mem_rdata[21:14];
            bank_apply_valid <= 1'b1;
            ms_left <= mem_rdata[13:0];
            tick <= 32'h0;
            state <= S_DWELL;
          end
        end
        S_DWELL: begin
          if (cmd_wr && op == `CMD_TESTING) begin // answered without stretching the dwell
            reply <= {31'h0, running};
            reply_valid <= 1'b1;
          end
          if (cmd_wr && op == `CMD_STOP) begin
            running <= 1'b0;
            tick <= 32'h0; // save and the next load count from zero
            state <= S_IDLE;
          end else if (tick < MS_CYCLES - 1) begin
            tick <= tick + 32'h1;
          end else begin
            tick <= 32'h0;
            if (ms_left > 14'h1) begin
              ms_left <= ms_left - 14'h1;
            end else if (run_step + 5'h1 < total_file[run_file]) begin
              run_step <= run_step + 5'h1;
              mem_addr <= {run_file, run_step[3:0] + 4'h1};
              state <= S_LOAD;
            end else if (run_left != 14'h0) begin
              run_left <= run_left - 14'h1;
              run_step <= 5'h0;
              mem_addr <= {run_file, 4'h0};
              state <= S_LOAD;
            end else begin
              running <= 1'b0;
              done_flag <= 1'b1;
              sequence_done <= 1'b1;
              reply <= 32'h0000_0001;
              reply_valid <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_ACK: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test/seq_engine_sva.sv
`timescale 1ns/1ps
`default_nettype none
module seq_engine_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [7:0] bank_apply,
  input wire logic bank_apply_valid,
  input wire logic sequence_done
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_done_pulse: assert property (sequence_done |=> !sequence_done)
    else $error("done pulse longer than one cycle");
  a_apply_gap: assert property (bank_apply_valid |=> !bank_apply_valid [*8])
    else $error("step applied again before its dwell");
  a_bank_range: assert property (bank_apply_valid |-> bank_apply inside {[8'h01:8'h96]})
    else $error("applied bank out of range");
  a_done_quiet: assert property (sequence_done |-> !bank_apply_valid)
    else $error("done while a step is applied");
  a_done_dwell: assert property (bank_apply_valid |-> ##1 !sequence_done [*8])
    else $error("done before last dwell ran");
  a_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("stall with no request");
  a_wait_bound: assert property ((read || write) && waitrequest |-> ##[1:200] !waitrequest)
    else $error("stall too long");
  a_reset_quiet: assert property ($rose(rstn) |-> !sequence_done && !bank_apply_valid)
    else $error("pulse right after reset");
  c_run_done: cover property (sequence_done);
  c_apply: cover property (bank_apply_valid ##1 !bank_apply_valid);
  c_stall: cover property (write && waitrequest);
endmodule
`default_nettype wire

// File: test/load_state_stub.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the load-state store; it only counts recalls, so it cannot hide a missed pulse
module load_state_stub (
  input wire logic clk,
  input wire logic [7:0] bank_apply,
  input wire logic bank_apply_valid,
  output var int n_applied
);
  initial n_applied = 0;
  // one recall per pulse
  always @(posedge clk) begin
    if (bank_apply_valid) begin
      n_applied <= n_applied + 1;
    end
  end
endmodule
`default_nettype wire

// File: test/auto_sequence_command_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "seq_consts.vh"
module auto_sequence_command_engine_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] bank_apply;
  logic bank_apply_valid;
  logic sequence_done;
  int n_fail = 0;
  int n_checks = 0;
  int n_done = 0;
  int n_applied;
  int cyc = 0;
  int last_apply = 0;
  int dwells[$];
  localparam int MS = 4;
  int seed = 32'h464f;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic [7:0] banks[$];
  logic [7:0] bk;
  always #12.5 clk = ~clk;
  auto_sequence_command_engine #(.MS_CYCLES(MS)) u_auto_sequence_command_engine (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .bank_apply(bank_apply), .bank_apply_valid(bank_apply_valid),
    .sequence_done(sequence_done));
  load_state_stub u_load_state_stub (.clk(clk), .bank_apply(bank_apply),
    .bank_apply_valid(bank_apply_valid), .n_applied(n_applied));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    finish_test;
  endtask
  // one edge of gap first, so a release and a new request never share a time step
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        break;
    end
    if (i == 300)
      hang;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    notes.push_back({m, e & m});
    bus(1'b1, a, 32'h0);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [31:0] arg);
    bus(1'b0, `OFF_ARG, arg);
    bus(1'b0, `OFF_CMD, {28'h0, c});
  endtask
  // a refused setting must raise the reject flag
  task automatic bad(input logic [3:0] c, input logic [31:0] arg);
    cmd(c, arg);
    rd(`OFF_STATUS, 32'h2, 32'h2);
  endtask
  task automatic reply(input logic [31:0] e);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(`OFF_STATUS, 32'h0, 32'h0);
      if (readdata[`ST_REPLY_VALID] === 1'b1)
        break;
    end
    if (i == 3000)
      hang;
    rd(`OFF_REPLY, 32'hffffffff, e);
  endtask
  task automatic qry(input logic [3:0] c, input logic [31:0] e);
    bus(1'b0, `OFF_CMD, {27'h0, 1'b1, c});
    reply(e);
  endtask
  // the oldest note belongs to the read that completes now
  always @(posedge clk) begin
    cyc++;
    if (read && waitrequest === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      check(readdata & note[63:32], note[31:0]);
    end
    // a step's dwell is the gap to the next apply, in whole milliseconds of MS cycles
    if (bank_apply_valid === 1'b1) begin
      check({24'h0, bank_apply}, {24'h0, banks.pop_front()});
      if (last_apply != 0)
        check((cyc - last_apply) / MS, dwells.pop_front());
      last_apply = cyc;
    end
    if (sequence_done === 1'b1) begin
      n_done++;
      last_apply = 0;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    qry(`CMD_FILE, 32'h1);
    qry(`CMD_STEP, 32'h1);
    qry(`CMD_TOTAL, 32'h1);
    qry(`CMD_REPEAT, 32'h0);
    rd(4'h2, 32'hffffffff, 32'h0);
    cmd(`CMD_FILE, 32'h5);
    bad(`CMD_FILE, 32'ha);
    qry(`CMD_FILE, 32'h5);
    bad(`CMD_STEP, 32'h11);
    bad(`CMD_STEP, 32'h0);
    cmd(`CMD_STEP, 32'h10);
    qry(`CMD_STEP, 32'h10);
    cmd(`CMD_TOTAL, 32'h2);
    bad(`CMD_TOTAL, 32'h11);
    qry(`CMD_TOTAL, 32'h2);
    // step 1 takes the top bank and shortest dwell, step 2 a random bank
    for (int s = 1; s <= 2; s++) begin
      bk = (s == 1) ? 8'h96 : 8'h01 + 8'($unsigned($random(seed)) % 150);
      cmd(`CMD_STEP, s);
      cmd(`CMD_BANK, {24'h0, bk});
      bad(`CMD_BANK, (s == 1) ? 32'h97 : 32'h0);
      cmd(`CMD_TIME, 32'h63 + s);
      bad(`CMD_TIME, 32'h63);
      qry(`CMD_BANK, {24'h0, bk});
      qry(`CMD_TIME, 32'h63 + s);
      banks.push_back(bk);
      dwells.push_back(32'h63 + s);
    end
    cmd(`CMD_REPEAT, 32'h1);
    bad(`CMD_REPEAT, 32'h2710);
    qry(`CMD_REPEAT, 32'h1);
    cmd(`CMD_SAVE, 32'h0);
    cmd(`CMD_FILE, 32'h1);
    qry(`CMD_TOTAL, 32'h1);
    cmd(`CMD_FILE, 32'h5);
    qry(`CMD_TOTAL, 32'h2);
    banks = {banks, banks};
    dwells = {dwells, dwells};
    bad(`CMD_RUN, 32'ha);
    cmd(`CMD_RUN, 32'h5);
    qry(`CMD_TESTING, 32'h1);
    reply(32'h1);
    qry(`CMD_TESTING, 32'h0);
    // a second run is cut short by stop: one step applied, no completion
    banks.push_back(8'h96);
    cmd(`CMD_RUN, 32'h5);
    cmd(`CMD_STOP, 32'h0);
    qry(`CMD_TESTING, 32'h0);
    check(n_done, 32'h1);
    check(n_applied, 32'h5);
    finish_test;
  end
endmodule
bind auto_sequence_command_engine seq_engine_sva u_seq_engine_sva (.clk, .rstn, .read,
  .write, .waitrequest, .bank_apply, .bank_apply_valid, .sequence_done);
`default_nettype wire
